// ---- rtl/flash_prot_pkg.sv ----
/*
  constants and types for the flash block erase and protection logic.
  assumes one system clock; the array is addressed by byte address.
*/
`default_nettype none

package flash_prot_pkg;
  localparam int          ADDR_W      = 16;       // 64 KB byte address
  localparam int          DATA_W      = 32;
  localparam int          WORDS       = 16384;    // 64 KB of 32-bit words
  localparam int          WIDX_W      = 14;       // word index width
  localparam int          WIDX_LSB    = 2;        // byte address to word
  localparam int          BLK_LSB     = 10;       // 1 KB erase block
  localparam int          BLK_W       = 6;        // 64 erase blocks
  localparam int          UNIT_LSB    = 11;       // 2 KB protection unit
  localparam int          UNIT_W      = 5;
  localparam int          UNITS       = 32;
  localparam int          OFS_W       = 8;        // 256 words per block
  localparam logic [7:0]  OFS_LAST    = 8'hFF;
  localparam logic [7:0]  OFS_ZERO    = 8'h00;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [31:0] DENY_WORD   = 32'h0000_0000;
  localparam logic [8:0]  ERASE_LEN   = 9'h100;   // words per erase

  // who is asking for a read
  typedef enum logic [1:0] {SRC_FETCH, SRC_DATA, SRC_DEBUG} src_t;

  typedef enum logic {ST_IDLE, ST_ERASE} state_t;
endpackage : flash_prot_pkg

`default_nettype wire

// ---- rtl/flash_block_erase_protect.sv ----
/*
  flash array with per-block erase and per-unit read-only / execute-only
  protection, screening fetch, data and debugger reads.
  assumes requests and protection settings come from logic on clk_sys;
  array contents are not cleared by reset, as with real flash.
*/
// Behaviour
// - 64 KB array in 1 KB blocks; erasing one block touches no other.
// - a finished erase leaves every bit of the block at one.
// - protection is set per 2 KB unit, two adjacent erase blocks.
// - each unit may be read-only or execute-only, independently.
// - read-only units refuse every erase and program request.
// - execute-only units refuse writes; only instruction fetch may read.
// - execute-only units deny data reads and debugger reads.
// - a permitted read completes in one clock, no wait states.
`default_nettype none

module flash_block_erase_protect
  import flash_prot_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic [UNITS-1:0]            prot_ro,
  input  wire logic [UNITS-1:0]            prot_xo,
  input  wire logic                        rd_req,
  input  wire logic [flash_prot_pkg::ADDR_W-1:0] rd_addr,
  input  wire flash_prot_pkg::src_t        rd_src,
  output logic                             rd_valid,
  output logic                             rd_denied,
  output logic [flash_prot_pkg::DATA_W-1:0] rd_data,
  input  wire logic                        erase_req,
  input  wire logic [flash_prot_pkg::ADDR_W-1:0] erase_addr,
  input  wire logic                        prog_req,
  input  wire logic [flash_prot_pkg::ADDR_W-1:0] prog_addr,
  input  wire logic [flash_prot_pkg::DATA_W-1:0] prog_data,
  output logic                             busy,
  output logic                             wr_done,
  output logic                             wr_refused
);
  import flash_prot_pkg::*;

  logic [DATA_W-1:0] mem [WORDS];

  state_t             state_r,    state_nxt;
  logic [BLK_W-1:0]   blk_r,      blk_nxt;
  logic [OFS_W-1:0]   ofs_r,      ofs_nxt;
  logic               done_r,     done_nxt;
  logic               refused_r,  refused_nxt;
  logic               rvalid_r,   rvalid_nxt;
  logic               rdeny_r,    rdeny_nxt;
  logic [DATA_W-1:0]  rdata_r,    rdata_nxt;

  logic               mem_we;
  logic [WIDX_W-1:0]  mem_widx;
  logic [DATA_W-1:0]  mem_wdata;
  logic [UNIT_W-1:0]  rd_unit;
  logic [UNIT_W-1:0]  er_unit;
  logic [UNIT_W-1:0]  pg_unit;
  logic               er_locked;
  logic               pg_locked;
  logic               rd_allow;
  logic [WIDX_W-1:0]  pg_idx;

  // unit index is the address above bit 10
  assign rd_unit   = rd_addr[ADDR_W-1:UNIT_LSB];
  assign er_unit   = erase_addr[ADDR_W-1:UNIT_LSB];
  assign pg_unit   = prog_addr[ADDR_W-1:UNIT_LSB];
  assign pg_idx    = prog_addr[ADDR_W-1:WIDX_LSB];
  // either kind of protection makes the unit unwritable
  assign er_locked = prot_ro[er_unit] | prot_xo[er_unit];
  assign pg_locked = prot_ro[pg_unit] | prot_xo[pg_unit];
  // execute-only hides data from everyone but instruction fetch
  assign rd_allow  = !prot_xo[rd_unit] || (rd_src == SRC_FETCH);

  // read path: one registered stage, answer on the next edge
  always_comb
  begin
    rvalid_nxt = 1'b0;
    rdeny_nxt  = 1'b0;
    rdata_nxt  = rdata_r;
    if (rd_req)
    begin
      rvalid_nxt = 1'b1;
      if (rd_allow)
        rdata_nxt = mem[rd_addr[ADDR_W-1:WIDX_LSB]];
      else
      begin
        rdeny_nxt = 1'b1;
        rdata_nxt = DENY_WORD; // no leak of protected contents
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rvalid_r <= 1'b0;
      rdeny_r  <= 1'b0;
      rdata_r  <= DENY_WORD;
    end
    else if (clk_en)
    begin
      rvalid_r <= rvalid_nxt;
      rdeny_r  <= rdeny_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // write path: erase wins over program; requests while busy are ignored.
  // erase walks the block one word a cycle, trading speed for a plain
  // single-port array.
  always_comb
  begin
    state_nxt   = state_r;
    blk_nxt     = blk_r;
    ofs_nxt     = ofs_r;
    done_nxt    = 1'b0;
    refused_nxt = 1'b0;
    mem_we      = 1'b0;
    mem_widx    = pg_idx;
    mem_wdata   = prog_data;
    case (state_r)
      ST_IDLE:
      begin
        if (erase_req)
        begin
          if (er_locked)
            refused_nxt = 1'b1;
          else
          begin
            state_nxt = ST_ERASE;
            blk_nxt   = erase_addr[ADDR_W-1:BLK_LSB];
            ofs_nxt   = OFS_ZERO;
          end
        end
        else if (prog_req)
        begin
          if (pg_locked)
            refused_nxt = 1'b1;
          else
          begin
            mem_we    = clk_en;
            // programming only clears bits, like the cells themselves
            mem_wdata = mem[pg_idx] & prog_data;
            done_nxt  = 1'b1;
          end
        end
      end
      ST_ERASE:
      begin
        mem_we    = clk_en;
        mem_widx  = {blk_r, ofs_r};
        mem_wdata = ERASED_WORD;
        ofs_nxt   = ofs_r + 8'h01;
        if (ofs_r == OFS_LAST)
        begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r   <= ST_IDLE;
      blk_r     <= '0;
      ofs_r     <= OFS_ZERO;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r   <= state_nxt;
      blk_r     <= blk_nxt;
      ofs_r     <= ofs_nxt;
      done_r    <= done_nxt;
      refused_r <= refused_nxt;
    end
  end

  // the array has no reset: flash keeps its contents
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      mem[mem_widx] <= mem_wdata;
  end

  assign rd_valid   = rvalid_r;
  assign rd_denied  = rdeny_r;
  assign rd_data    = rdata_r;
  assign busy       = (state_r == ST_ERASE);
  assign wr_done    = done_r;
  assign wr_refused = refused_r;

  // checks ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic [8:0] erase_cnt_r; // cycles spent erasing, for the length check
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      erase_cnt_r <= '0;
    else if (clk_en)
      erase_cnt_r <= busy ? erase_cnt_r + 9'h001 : 9'h000;
  end

  sequence locked_write_s;
    clk_en && !busy && ((erase_req && er_locked) ||
                        (!erase_req && prog_req && pg_locked));
  endsequence

  sequence foreign_xo_read_s;
    clk_en && rd_req && prot_xo[rd_unit] && rd_src != SRC_FETCH;
  endsequence

  refuse_locked_a: assert property (locked_write_s |->
    !mem_we ##1 wr_refused && !wr_done && !busy)
    else $error("write to protected unit was not refused");
  xo_read_deny_a: assert property (foreign_xo_read_s |=>
    rd_valid && rd_denied && rd_data == DENY_WORD)
    else $error("execute-only data leaked to non-fetch read");
  xo_fetch_ok_a: assert property (clk_en && rd_req && rd_src == SRC_FETCH
    |=> rd_valid && !rd_denied)
    else $error("instruction fetch was denied");
  ro_read_ok_a: assert property (clk_en && rd_req && !prot_xo[rd_unit]
    |=> !rd_denied)
    else $error("read of a non execute-only unit was denied");
  // back-to-back reads are legal, so the pulse rule is split in two:
  // a taken request answers next edge, an idle enabled edge clears it
  read_one_cycle_a: assert property (clk_en && rd_req |=> rd_valid)
    else $error("read answer not one cycle after request");
  read_pulse_a: assert property (clk_en && !rd_req |=> !rd_valid)
    else $error("read answer stood longer than one cycle");
  erase_stays_a: assert property (busy && mem_we
    |-> mem_widx[WIDX_W-1:OFS_W] == blk_r)
    else $error("erase wrote outside its block");
  erase_fill_a: assert property (busy && clk_en
    |-> mem_we && mem_wdata == ERASED_WORD)
    else $error("erase wrote a word other than all ones");
  erase_len_a: assert property ($fell(busy) |->
    erase_cnt_r == ERASE_LEN && wr_done)
    else $error("erase did not cover exactly one block");
  unit_index_a: assert property (clk_en && !busy && prog_req && !erase_req
    |=> wr_refused == $past(pg_locked))
    else $error("program decision used the wrong unit");
endmodule : flash_block_erase_protect

`default_nettype wire

// ---- testbench/fetch_debug_requester.sv ----
/*
  model of the read side of the array: fetch path, data path and debugger.
  assumes the bench raises go with addr and src just after a clock edge.
*/
`default_nettype none

module fetch_debug_requester
  import flash_prot_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        go,
  input  wire logic [flash_prot_pkg::ADDR_W-1:0] addr,
  input  wire flash_prot_pkg::src_t        src,
  output logic                             rd_req,
  output logic [flash_prot_pkg::ADDR_W-1:0] rd_addr,
  output flash_prot_pkg::src_t             rd_src
);
  logic [15:0] idle_r = 16'h5A3C;

  // idle lines churn so a stale address can never look like a request
  always_ff @(posedge clk_sys)
    idle_r <= idle_r + 16'h3C5B;

  assign rd_req  = go;
  assign rd_addr = go ? addr : idle_r;
  assign rd_src  = go ? src : src_t'(idle_r[1:0]);
endmodule : fetch_debug_requester

`default_nettype wire

// ---- testbench/tb_flash_block_erase_protect.sv ----
/*
  self-checking bench for the flash erase and protection block.
  assumes the requester model drives the read port; writes come from here.
*/
`default_nettype none
`define CHK(a, b) num_checks++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end

module tb_flash_block_erase_protect
  import flash_prot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys   = 1'b0;
  logic              reset     = 1'b1;
  logic              clk_en    = 1'b1;
  logic [UNITS-1:0]  prot_ro   = '0;
  logic [UNITS-1:0]  prot_xo   = '0;
  logic              go        = 1'b0;
  logic [ADDR_W-1:0] addr      = '0;
  src_t              src       = SRC_FETCH;
  logic              erase_req = 1'b0;
  logic              prog_req  = 1'b0;
  logic [ADDR_W-1:0] wr_addr   = '0;
  logic [DATA_W-1:0] prog_data = '0;
  logic              rd_req, rd_valid, rd_denied, busy, wr_done, wr_refused;
  logic [ADDR_W-1:0] rd_addr;
  src_t              rd_src;
  logic [DATA_W-1:0] rd_data;
  int                errors    = 0;
  int                num_checks = 0;

  always #50 clk_sys = ~clk_sys;

  fetch_debug_requester u_req (.clk_sys(clk_sys), .go(go), .addr(addr),
    .src(src), .rd_req(rd_req), .rd_addr(rd_addr), .rd_src(rd_src));

  flash_block_erase_protect u_dut (.clk_sys(clk_sys), .reset(reset),
    .clk_en(clk_en), .prot_ro(prot_ro), .prot_xo(prot_xo), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_src(rd_src), .rd_valid(rd_valid),
    .rd_denied(rd_denied), .rd_data(rd_data), .erase_req(erase_req),
    .erase_addr(wr_addr), .prog_req(prog_req), .prog_addr(wr_addr),
    .prog_data(prog_data), .busy(busy), .wr_done(wr_done),
    .wr_refused(wr_refused));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // one read, answered exactly one edge after it is taken
  task automatic rd(input logic [15:0] a, input src_t s, input logic den,
                    input logic [31:0] exp);
    @(posedge clk_sys);
    #1 go = 1'b1;
    addr = a;
    src = s;
    @(posedge clk_sys);
    #1 go = 1'b0;
    `CHK(rd_valid, 1'b1)
    `CHK(rd_denied, den)
    `CHK(rd_data, exp)
  endtask : rd

  // erase (er=1) or program; an accepted erase is timed to the cycle
  task automatic wr(input logic er, input logic [15:0] a,
                    input logic [31:0] d, input logic refuse);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1 erase_req = er;
    prog_req = !er;
    wr_addr = a;
    prog_data = d;
    @(posedge clk_sys);
    #1 erase_req = 1'b0;
    prog_req = 1'b0;
    `CHK(wr_refused, refuse)
    if (er && !refuse)
    begin
      `CHK(busy, 1'b1)
      while (busy === 1'b1 && n < 400)
      begin
        @(posedge clk_sys);
        #1 n++;
      end
      `CHK(n, 256)
      if (n >= 400)
        end_of_test();
    end
    `CHK(wr_done, !refuse)
  endtask : wr

  // erasing one block leaves its neighbour alone and reads all ones
  task automatic t_erase;
    for (int b = 0; b < 3; b++)
      wr(1'b1, 16'(b * 1024), '0, 1'b0);
    wr(1'b0, 16'h0400, 32'h1234_5678, 1'b0);
    wr(1'b1, 16'h0000, '0, 1'b0);
    rd(16'h03FC, SRC_DATA, 1'b0, 32'hFFFF_FFFF);
    rd(16'h0400, SRC_DEBUG, 1'b0, 32'h1234_5678);
    $display("test erase done");
  endtask : t_erase

  // read-only unit 0: both write kinds bounce, contents stay readable
  task automatic t_ro;
    prot_ro = 32'h0000_0001;
    wr(1'b0, 16'h0400, 32'h0000_0000, 1'b1);
    wr(1'b1, 16'h0400, '0, 1'b1);
    rd(16'h0400, SRC_DATA, 1'b0, 32'h1234_5678);
    prot_ro = '0;
    $display("test read_only done");
  endtask : t_ro

  // execute-only unit 1 covers blocks 2 and 3; unit 0 stays open
  task automatic t_xo;
    prot_xo = 32'h0000_0002;
    rd(16'h0800, SRC_FETCH, 1'b0, 32'hFFFF_FFFF);
    rd(16'h0800, SRC_DATA, 1'b1, 32'h0000_0000);
    rd(16'h0FFC, SRC_DEBUG, 1'b1, 32'h0000_0000);
    rd(16'h07FC, SRC_DATA, 1'b0, 32'hFFFF_FFFF);
    wr(1'b0, 16'h0800, 32'h0000_0000, 1'b1);
    wr(1'b1, 16'h0C00, '0, 1'b1);
    wr(1'b0, 16'h0004, 32'hA5A5_0F0F, 1'b0);
    rd(16'h0004, SRC_DATA, 1'b0, 32'hA5A5_0F0F);
    rd(16'h0800, SRC_FETCH, 1'b0, 32'hFFFF_FFFF);
    prot_xo = '0;
    $display("test execute_only done");
  endtask : t_xo

  // clk_en low mid-erase: the erase stalls and a read is not taken
  task automatic t_hold;
    int n;
    n = 0;
    @(posedge clk_sys);
    #1 erase_req = 1'b1;
    wr_addr = 16'h0800;
    @(posedge clk_sys);
    #1 erase_req = 1'b0;
    clk_en = 1'b0;
    go = 1'b1;
    addr = 16'h0004;
    src = SRC_DATA;
    repeat (10) @(posedge clk_sys);
    #1 go = 1'b0;
    clk_en = 1'b1;
    `CHK(busy, 1'b1)
    `CHK(rd_valid, 1'b0)
    while (busy === 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(n, 256)
    `CHK(wr_done, 1'b1)
    if (n >= 400)
      end_of_test();
    $display("test clock_enable done");
  endtask : t_hold

  // reset in mid-erase clears every output but keeps the array
  task automatic t_reset;
    @(posedge clk_sys);
    #1 erase_req = 1'b1;
    wr_addr = 16'h0800;
    @(posedge clk_sys);
    #1 erase_req = 1'b0;
    reset = 1'b1;
    @(posedge clk_sys);
    #1 reset = 1'b0;
    `CHK(busy, 1'b0)
    `CHK(wr_done, 1'b0)
    `CHK(rd_valid, 1'b0)
    `CHK(rd_data, DENY_WORD)
    rd(16'h0004, SRC_DATA, 1'b0, 32'hA5A5_0F0F);
    $display("test reset done");
  endtask : t_reset

  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_erase();
    t_ro();
    t_xo();
    t_hold();
    t_reset();
    end_of_test();
  end
endmodule : tb_flash_block_erase_protect

`default_nettype wire
